//--- design/bififo_defines.svh
// Constants for the bidirectional FIFO: register map, fields, resets, sizes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef BIFIFO_DEFINES_SVH
`define BIFIFO_DEFINES_SVH

// Data path and storage
`define DATA_W 18
`define PTR_W 8
`define CNT_W 9
`define FIFO_DEPTH 9'h100
`define DEPTH_SUM 10'h100

// Almost-flag offset reset value
`define OFFSET_RESET 9'h008

// Register byte addresses
`define ADR_CTRL 8'h00
`define ADR_FLAGS 8'h04
`define ADR_A_DATA 8'h08
`define ADR_OFFSET_BASE 8'h0C
`define ADR_IRQ_STATUS 8'h1C
`define ADR_IRQ_MASK 8'h20
`define ADR_COUNTS 8'h24

// Field positions
`define CTRL_BYPASS 0
`define FLAGS_BYPASS_N 8
`define COUNT_BA_LSB 16

// Offset register slots
`define NUM_OFFSETS 4
`define OFS_PAE_AB 0
`define OFS_PAF_AB 1
`define OFS_PAE_BA 2
`define OFS_PAF_BA 3

// Interrupt events
`define IRQ_W 4
`define IRQ_BA_DATA 0
`define IRQ_AB_SPACE 1
`define IRQ_A_DROP 2
`define IRQ_BA_ALMOST_FULL 3

`endif

//--- design/bififo_pkg.sv
// Types shared by the bidirectional FIFO design files.
// Assumes nothing of its surroundings.
package bififo_pkg;

    typedef enum logic [1:0] {PB_IDLE, PB_READ, PB_WRITE} port_b_op_type;

endpackage

//--- design/fifo_store.sv
// One 256 x 18 storage buffer with show-ahead head word and fill count.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module fifo_store
    import bififo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [`DATA_W-1:0] push_data,
    input wire logic pop,
    output logic [`DATA_W-1:0] head_data,
    output logic [`CNT_W-1:0] count
);

    logic [`DATA_W-1:0] mem [0:255];
    logic [`PTR_W-1:0] wr_ptr_reg;
    logic [`PTR_W-1:0] rd_ptr_reg;
    logic [`CNT_W-1:0] count_reg;

    // Memory is not reset; pointers alone define contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= 8'h00;
            rd_ptr_reg <= 8'h00;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 8'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= 9'h000;
        end else if (push && !pop) begin
            count_reg <= count_reg + 9'h001;
        end else if (pop && !push) begin
            count_reg <= count_reg - 9'h001;
        end
    end

    assign head_data = mem[rd_ptr_reg];
    assign count = count_reg;

endmodule

//--- design/flag_calc.sv
// Registered empty, full and almost flags for one direction, all active low.
// Assumes count and offsets belong to the same clock as the flags.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module flag_calc
    import bififo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CNT_W-1:0] count,
    input wire logic [`CNT_W-1:0] ae_offset,
    input wire logic [`CNT_W-1:0] af_offset,
    input wire logic bypass_mode,
    input wire logic bypass_valid,
    output logic empty_n,
    output logic full_n,
    output logic almost_empty_n,
    output logic almost_full_n
);

    logic [`CNT_W:0] fill_sum;

    // Sum form avoids underflow when the offset exceeds the depth
    assign fill_sum = {1'b0, count} + {1'b0, af_offset};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            empty_n <= 1'b0;
            full_n <= 1'b1;
            almost_empty_n <= 1'b0;
            almost_full_n <= 1'b1;
        end else begin
            if (bypass_mode) begin
                empty_n <= bypass_valid;
                full_n <= !bypass_valid;
            end else begin
                empty_n <= (count != 9'h000);
                full_n <= (count != `FIFO_DEPTH);
            end
            almost_empty_n <= (count > ae_offset);
            almost_full_n <= !(fill_sum > `DEPTH_SUM);
        end
    end

endmodule

//--- design/bififo_portb.sv
// Bidirectional FIFO core: Port B pins, Port A over Wishbone, all flags.
// Assumes one 40 MHz clock for both ports and a synchronous active-low reset.
//
// Overview of operation
// - Port B transfers are sampled or launched on the rising clock edge.
// - Port B moves data only while its enable is low.
// - Reading Port B drives the data bus only while output enable is low.
// - A-to-B empty flag low when that buffer is empty; Port B reads blocked.
// - B-to-A empty flag low when that buffer is empty; Port A reads blocked.
// - A-to-B full flag low when full; Port A writes then ignored.
// - B-to-A full flag low when full; Port B writes then ignored.
// - Almost-empty low when count is at most its offset, default eight.
// - Almost-full low when count exceeds depth minus its offset, default eight.
// - Bypass: A-to-B empty high while a word waits, low once Port B reads.
// - Bypass: B-to-A empty drops the cycle after Port A reads the word.
// - Bypass: A-to-B full low while a message waits for Port B.
// - Bypass: B-to-A full low while a message waits for Port A.
// - Port B bypass indicator low while Port A has selected bypass.
// - Reset low clears both buffers and the bypass state; empty and almost-empty flags go low, the rest high.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module bififo_portb
    import bififo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic port_b_enable_n,
    input wire logic port_b_output_enable_n,
    input wire logic port_b_read_write,
    input wire logic [`DATA_W-1:0] port_b_data_in,
    output logic [`DATA_W-1:0] port_b_data_out,
    output logic port_b_data_oe_n,
    output logic a_to_b_empty_n,
    output logic a_to_b_almost_empty_n,
    output logic a_to_b_almost_full_n,
    output logic a_to_b_full_n,
    output logic b_to_a_empty_n,
    output logic b_to_a_almost_empty_n,
    output logic b_to_a_almost_full_n,
    output logic b_to_a_full_n,
    output logic port_b_bypass_active_n
);

    port_b_op_type port_b_op;
    logic bypass_reg;
    logic [`CNT_W-1:0] offset_reg [0:`NUM_OFFSETS-1];
    logic [`IRQ_W-1:0] irq_status_reg;
    logic [`IRQ_W-1:0] irq_mask_reg;
    logic [`IRQ_W-1:0] irq_event;
    logic [`DATA_W-1:0] byp_ab_data_reg;
    logic [`DATA_W-1:0] byp_ba_data_reg;
    logic byp_ab_valid_reg;
    logic byp_ba_valid_reg;
    logic ack_reg;
    logic [31:0] dat_o_reg;
    logic [31:0] rd_mux;
    logic irq_reg;
    logic [`DATA_W-1:0] data_out_reg;
    logic data_oe_n_reg;
    logic ba_empty_n_prev_reg;
    logic ab_full_n_prev_reg;
    logic ba_af_n_prev_reg;

    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic a_data_hit;
    logic full_word;

    logic [`DATA_W-1:0] ab_head;
    logic [`DATA_W-1:0] ba_head;
    logic [`CNT_W-1:0] ab_count;
    logic [`CNT_W-1:0] ba_count;
    logic ab_push;
    logic ab_pop;
    logic ba_push;
    logic ba_pop;
    logic ab_has_room;
    logic ba_has_room;
    logic pb_byp_read;
    logic pb_byp_write;
    logic a_byp_write;
    logic a_byp_read;
    logic a_write_drop;

    // Port B command decode; enable high means no transfer
    always_comb begin
        port_b_op = PB_IDLE;
        case ({port_b_enable_n, port_b_read_write})
            2'b00: port_b_op = PB_WRITE;
            2'b01: port_b_op = PB_READ;
            default: port_b_op = PB_IDLE;
        endcase
    end

    // Wishbone request taken once; ack answers one edge later
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr = wb_req && wb_we_i;
    assign wb_rd = wb_req && !wb_we_i;
    assign a_data_hit = (wb_adr_i == `ADR_A_DATA);
    // A data word spans three lanes; partial writes would tear it
    assign full_word = (wb_sel_i[2:0] == 3'h7);

    assign ab_has_room = (ab_count != `FIFO_DEPTH);
    assign ba_has_room = (ba_count != `FIFO_DEPTH);

    // Port A side through the bus
    assign ab_push = wb_wr && a_data_hit && full_word && !bypass_reg && ab_has_room;
    assign ba_pop = wb_rd && a_data_hit && !bypass_reg && (ba_count != 9'h000);
    assign a_byp_write = wb_wr && a_data_hit && full_word && bypass_reg
        && !byp_ab_valid_reg;
    assign a_byp_read = wb_rd && a_data_hit && bypass_reg && byp_ba_valid_reg;
    assign a_write_drop = wb_wr && a_data_hit && full_word && !ab_push && !a_byp_write;

    // Port B side on the pins
    assign ab_pop = (port_b_op == PB_READ) && !bypass_reg && (ab_count != 9'h000);
    assign ba_push = (port_b_op == PB_WRITE) && !bypass_reg && ba_has_room;
    assign pb_byp_read = (port_b_op == PB_READ) && bypass_reg && byp_ab_valid_reg;
    assign pb_byp_write = (port_b_op == PB_WRITE) && bypass_reg
        && !byp_ba_valid_reg;

    fifo_store ab_store (
        .clk(clk),
        .rst_n(rst_n),
        .push(ab_push),
        .push_data(wb_dat_i[`DATA_W-1:0]),
        .pop(ab_pop),
        .head_data(ab_head),
        .count(ab_count)
    );

    fifo_store ba_store (
        .clk(clk),
        .rst_n(rst_n),
        .push(ba_push),
        .push_data(port_b_data_in),
        .pop(ba_pop),
        .head_data(ba_head),
        .count(ba_count)
    );

    // A-to-B flags: empty side faces Port B, full side faces Port A
    flag_calc ab_flags (
        .clk(clk),
        .rst_n(rst_n),
        .count(ab_count),
        .ae_offset(offset_reg[`OFS_PAE_AB]),
        .af_offset(offset_reg[`OFS_PAF_AB]),
        .bypass_mode(bypass_reg),
        .bypass_valid(byp_ab_valid_reg),
        .empty_n(a_to_b_empty_n),
        .full_n(a_to_b_full_n),
        .almost_empty_n(a_to_b_almost_empty_n),
        .almost_full_n(a_to_b_almost_full_n)
    );

    // B-to-A flags; registered, so a bypass read clears them one edge later
    flag_calc ba_flags (
        .clk(clk),
        .rst_n(rst_n),
        .count(ba_count),
        .ae_offset(offset_reg[`OFS_PAE_BA]),
        .af_offset(offset_reg[`OFS_PAF_BA]),
        .bypass_mode(bypass_reg),
        .bypass_valid(byp_ba_valid_reg),
        .empty_n(b_to_a_empty_n),
        .full_n(b_to_a_full_n),
        .almost_empty_n(b_to_a_almost_empty_n),
        .almost_full_n(b_to_a_almost_full_n)
    );

    // Bypass mode control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bypass_reg <= 1'b0;
        end else if (wb_wr && (wb_adr_i == `ADR_CTRL) && wb_sel_i[0]) begin
            bypass_reg <= wb_dat_i[`CTRL_BYPASS];
        end
    end

    // Bypass A-to-B message register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byp_ab_valid_reg <= 1'b0;
            byp_ab_data_reg <= '0;
        end else if (!bypass_reg) begin
            byp_ab_valid_reg <= 1'b0;
        end else if (a_byp_write) begin
            byp_ab_valid_reg <= 1'b1;
            byp_ab_data_reg <= wb_dat_i[`DATA_W-1:0];
        end else if (pb_byp_read) begin
            byp_ab_valid_reg <= 1'b0;
        end
    end

    // Bypass B-to-A message register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byp_ba_valid_reg <= 1'b0;
            byp_ba_data_reg <= '0;
        end else if (!bypass_reg) begin
            byp_ba_valid_reg <= 1'b0;
        end else if (pb_byp_write) begin
            byp_ba_valid_reg <= 1'b1;
            byp_ba_data_reg <= port_b_data_in;
        end else if (a_byp_read) begin
            byp_ba_valid_reg <= 1'b0;
        end
    end

    // Almost-flag offsets, one register per slot
    genvar k;
    generate
        for (k = 0; k < `NUM_OFFSETS; k = k + 1) begin : g_offset
            localparam logic [7:0] SLOT_ADR = 8'(`ADR_OFFSET_BASE + 4 * k);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    offset_reg[k] <= `OFFSET_RESET;
                end else if (wb_wr && (wb_adr_i == SLOT_ADR)) begin
                    if (wb_sel_i[0]) begin
                        offset_reg[k][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        offset_reg[k][8] <= wb_dat_i[8];
                    end
                end
            end
        end
    endgenerate

    // Port B read data launch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_out_reg <= '0;
        end else if (ab_pop) begin
            data_out_reg <= ab_head;
        end else if (pb_byp_read) begin
            data_out_reg <= byp_ab_data_reg;
        end
    end

    // Drive only when reading with output enable low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_oe_n_reg <= 1'b1;
        end else begin
            data_oe_n_reg <= !(port_b_read_write && !port_b_output_enable_n);
        end
    end

    // Bypass indicator toward Port B
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_b_bypass_active_n <= 1'b1;
        end else begin
            port_b_bypass_active_n <= !bypass_reg;
        end
    end

    // Interrupt events from flag edges and dropped writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ba_empty_n_prev_reg <= 1'b0;
            ab_full_n_prev_reg <= 1'b1;
            ba_af_n_prev_reg <= 1'b1;
        end else begin
            ba_empty_n_prev_reg <= b_to_a_empty_n;
            ab_full_n_prev_reg <= a_to_b_full_n;
            ba_af_n_prev_reg <= b_to_a_almost_full_n;
        end
    end

    assign irq_event[`IRQ_BA_DATA] = b_to_a_empty_n && !ba_empty_n_prev_reg;
    assign irq_event[`IRQ_AB_SPACE] = a_to_b_full_n && !ab_full_n_prev_reg;
    assign irq_event[`IRQ_A_DROP] = a_write_drop;
    assign irq_event[`IRQ_BA_ALMOST_FULL] = !b_to_a_almost_full_n && ba_af_n_prev_reg;

    // Sticky status; a new event wins over a same-cycle clear
    genvar i;
    generate
        for (i = 0; i < `IRQ_W; i = i + 1) begin : g_irq
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    irq_status_reg[i] <= 1'b0;
                end else if (irq_event[i]) begin
                    irq_status_reg[i] <= 1'b1;
                end else if (wb_wr && (wb_adr_i == `ADR_IRQ_STATUS) && wb_sel_i[0]
                        && wb_dat_i[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_reg <= '0;
        end else if (wb_wr && (wb_adr_i == `ADR_IRQ_MASK) && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (wb_adr_i)
            `ADR_CTRL: rd_mux[`CTRL_BYPASS] = bypass_reg;
            `ADR_FLAGS: rd_mux[`FLAGS_BYPASS_N:0] = {port_b_bypass_active_n,
                b_to_a_full_n, b_to_a_almost_full_n, b_to_a_almost_empty_n,
                b_to_a_empty_n, a_to_b_full_n, a_to_b_almost_full_n,
                a_to_b_almost_empty_n, a_to_b_empty_n};
            `ADR_A_DATA: begin
                if (bypass_reg) begin
                    rd_mux[`DATA_W-1:0] = byp_ba_valid_reg ? byp_ba_data_reg : '0;
                end else if (ba_count != 9'h000) begin
                    rd_mux[`DATA_W-1:0] = ba_head;
                end
            end
            8'h0C: rd_mux[`CNT_W-1:0] = offset_reg[`OFS_PAE_AB];
            8'h10: rd_mux[`CNT_W-1:0] = offset_reg[`OFS_PAF_AB];
            8'h14: rd_mux[`CNT_W-1:0] = offset_reg[`OFS_PAE_BA];
            8'h18: rd_mux[`CNT_W-1:0] = offset_reg[`OFS_PAF_BA];
            `ADR_IRQ_STATUS: rd_mux[`IRQ_W-1:0] = irq_status_reg;
            `ADR_IRQ_MASK: rd_mux[`IRQ_W-1:0] = irq_mask_reg;
            `ADR_COUNTS: begin
                rd_mux[`CNT_W-1:0] = ab_count;
                rd_mux[`COUNT_BA_LSB+`CNT_W-1:`COUNT_BA_LSB] = ba_count;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Bus answer; pop on read happens at the same edge as ack rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_o_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_req;
            if (wb_rd) begin
                dat_o_reg <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_o_reg;
    assign irq_o = irq_reg;
    assign port_b_data_out = data_out_reg;
    assign port_b_data_oe_n = data_oe_n_reg;

endmodule

//--- sim/bififo_portb_chk.sv
// Checker for the empty and full flags, Port B output enable and bypass indicator.
// Assumes one clock and a synchronous active-low reset; bound to the core.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module bififo_portb_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic port_b_enable_n,
    input wire logic port_b_output_enable_n,
    input wire logic port_b_read_write,
    input wire logic port_b_data_oe_n,
    input wire logic a_to_b_empty_n,
    input wire logic a_to_b_full_n,
    input wire logic b_to_a_empty_n,
    input wire logic b_to_a_full_n,
    input wire logic port_b_bypass_active_n
);
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic c_wr;
    // Cyc stays up on the ack edge too, so causes are looked for two edges back
    assign a_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `ADR_A_DATA;
    assign a_rd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == `ADR_A_DATA;
    assign c_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `ADR_CTRL;
    assign b_wr = !port_b_enable_n && !port_b_read_write;
    assign b_rd = !port_b_enable_n && port_b_read_write;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    oe_follow_a: assert property (
        port_b_data_oe_n == !$past(port_b_read_write && !port_b_output_enable_n))
        else $error("output enable wrong");
    reset_flags_a: assert property ($rose(rst_n) |-> !a_to_b_empty_n &&
        !b_to_a_empty_n && a_to_b_full_n && b_to_a_full_n && port_b_bypass_active_n)
        else $error("flags wrong after reset");
    ab_fill_a: assert property ($rose(a_to_b_empty_n) |->
        $past(a_wr) || $past(a_wr, 2)) else $error("ab empty rose without write");
    // Reset moves flags too; an edge seen as reset lifts is not a transfer
    ab_drain_a: assert property ($past(rst_n) && $fell(a_to_b_empty_n) |->
        $past(b_rd) || $past(b_rd, 2)) else $error("ab empty fell without read");
    ba_fill_a: assert property ($rose(b_to_a_empty_n) |->
        $past(b_wr) || $past(b_wr, 2)) else $error("ba empty rose without write");
    ba_drain_a: assert property ($past(rst_n) && $fell(b_to_a_empty_n) |->
        $past(a_rd) || $past(a_rd, 2)) else $error("ba empty fell without read");
    ab_full_a: assert property ($fell(a_to_b_full_n) |->
        $past(a_wr) || $past(a_wr, 2)) else $error("ab full fell without write");
    ba_full_a: assert property ($fell(b_to_a_full_n) |->
        $past(b_wr) || $past(b_wr, 2)) else $error("ba full fell without write");
    bypass_ind_a: assert property ($past(rst_n) && $changed(port_b_bypass_active_n) |->
        $past(c_wr) || $past(c_wr, 2)) else $error("bypass flag moved alone");
endmodule

bind bififo_portb bififo_portb_chk u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .port_b_enable_n(port_b_enable_n), .port_b_output_enable_n(port_b_output_enable_n),
    .port_b_read_write(port_b_read_write), .port_b_data_oe_n(port_b_data_oe_n),
    .a_to_b_empty_n(a_to_b_empty_n), .a_to_b_full_n(a_to_b_full_n),
    .b_to_a_empty_n(b_to_a_empty_n), .b_to_a_full_n(b_to_a_full_n),
    .port_b_bypass_active_n(port_b_bypass_active_n));

//--- sim/port_b_master.sv
// Port B master model: one enable-qualified transfer per call.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module port_b_master (
    input wire logic clk,
    output logic en_n,
    output logic oe_n,
    output logic rw,
    output logic [`DATA_W-1:0] wdat,
    input wire logic [`DATA_W-1:0] rdat
);
    initial begin
        en_n = 1'b1;
        oe_n = 1'b1;
        rw = 1'b0;
        wdat = '0;
    end
    // Two cycles a call: read data taken an edge later, free of races
    task automatic xfer(input logic rd, input logic [`DATA_W-1:0] d,
        output logic [`DATA_W-1:0] q);
        en_n <= 1'b0;
        rw <= rd;
        oe_n <= !rd;
        wdat <= d;
        @(posedge clk);
        en_n <= 1'b1;
        wdat <= ~d;
        @(posedge clk);
        q = rdat;
    endtask
endmodule

//--- sim/bififo_portb_test.sv
// Self-checking bench for the bidirectional FIFO core.
// Assumes the Port B master model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "bififo_defines.svh"
module bififo_portb_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, irq, oe_n_out, en_n, oe_n, rw;
    logic [`DATA_W-1:0] b_in, b_out, q;
    wire [8:0] fl;
    int err_count = 0;
    int compares = 0;
    always #12.5 clk = ~clk;
    bififo_portb u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .port_b_enable_n(en_n), .port_b_output_enable_n(oe_n),
        .port_b_read_write(rw), .port_b_data_in(b_in), .port_b_data_out(b_out),
        .port_b_data_oe_n(oe_n_out), .a_to_b_empty_n(fl[0]), .a_to_b_almost_empty_n(fl[1]),
        .a_to_b_almost_full_n(fl[2]), .a_to_b_full_n(fl[3]), .b_to_a_empty_n(fl[4]),
        .b_to_a_almost_empty_n(fl[5]), .b_to_a_almost_full_n(fl[6]), .b_to_a_full_n(fl[7]),
        .port_b_bypass_active_n(fl[8]));
    port_b_master u_pb (.clk(clk), .en_n(en_n), .oe_n(oe_n), .rw(rw), .wdat(b_in),
        .rdat(b_out));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                break;
            end
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (i == 16) begin
            err_count++;
            test_done;
        end
    endtask
    // Order: full, almost full, almost empty, empty, as on the flag pins
    function automatic logic [3:0] lvl(int n);
        return {n < `FIFO_DEPTH, n + `OFFSET_RESET <= `FIFO_DEPTH, n > `OFFSET_RESET, n > 0};
    endfunction
    task automatic a_to_b;
        int n;
        for (n = 1; n <= 256; n++) begin
            wb(1'b1, `ADR_A_DATA, n);
            repeat (2) @(posedge clk);
            chk("ab flags", lvl(n), fl[3:0]);
        end
        wb(1'b1, `ADR_A_DATA, 32'h3FFFF);
        wb(1'b0, `ADR_IRQ_STATUS, 0);
        chk("drop status", 1, rdat[`IRQ_A_DROP]);
        chk("irq masked", 0, irq);
        wb(1'b1, `ADR_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq raised", 1, irq);
        wb(1'b1, `ADR_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq cleared", 0, irq);
        for (n = 256; n >= 1; n--) begin
            u_pb.xfer(1'b1, '0, q);
            chk("b data", 257 - n, q);
            chk("b oe", 0, oe_n_out);
            @(posedge clk);
            chk("ab flags", lvl(n - 1), fl[3:0]);
        end
        u_pb.xfer(1'b1, '0, q);
        chk("empty b read", 256, q);
    endtask
    task automatic b_to_a;
        int n;
        for (n = 1; n <= 256; n++) begin
            u_pb.xfer(1'b0, `DATA_W'(n + 256), q);
            @(posedge clk);
            chk("ba flags", lvl(n), fl[7:4]);
        end
        chk("b oe off", 1, oe_n_out);
        u_pb.xfer(1'b0, 18'h3FFFF, q);
        for (n = 256; n >= 1; n--) begin
            wb(1'b0, `ADR_A_DATA, 0);
            chk("a data", 513 - n, rdat);
            repeat (2) @(posedge clk);
            chk("ba flags", lvl(n - 1), fl[7:4]);
        end
        wb(1'b0, `ADR_A_DATA, 0);
        chk("empty a read", 0, rdat);
        wb(1'b0, `ADR_IRQ_STATUS, 0);
        chk("irq events", 32'hB, rdat);
    endtask
    task automatic bypass;
        wb(1'b1, `ADR_CTRL, 1);
        repeat (2) @(posedge clk);
        chk("bypass on", 0, fl[8]);
        wb(1'b1, `ADR_A_DATA, 32'h2A5A5);
        repeat (2) @(posedge clk);
        chk("ab msg", 2'b01, {fl[3], fl[0]});
        u_pb.xfer(1'b1, '0, q);
        chk("ab msg data", 32'h2A5A5, q);
        @(posedge clk);
        chk("ab msg gone", 2'b10, {fl[3], fl[0]});
        u_pb.xfer(1'b0, 18'h15A5A, q);
        @(posedge clk);
        chk("ba msg", 2'b01, {fl[7], fl[4]});
        wb(1'b0, `ADR_A_DATA, 0);
        chk("ba msg data", 32'h15A5A, rdat);
        repeat (2) @(posedge clk);
        chk("ba msg gone", 2'b10, {fl[7], fl[4]});
        wb(1'b1, `ADR_CTRL, 0);
        repeat (2) @(posedge clk);
        chk("bypass off", 1, fl[8]);
    endtask
    task automatic mid_reset;
        wb(1'b1, `ADR_OFFSET_BASE, 0);
        wb(1'b1, `ADR_A_DATA, 7);
        chk("ae offset zero", 1, fl[1]);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("mid reset flags", 9'h1CC, fl);
        wb(1'b0, `ADR_COUNTS, 0);
        chk("mid reset counts", 0, rdat);
        wb(1'b0, `ADR_OFFSET_BASE, 0);
        chk("offset restored", `OFFSET_RESET, rdat);
    endtask
    initial begin
        int n;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset flags", 9'h1CC, fl);
        chk("reset oe", 1, oe_n_out);
        for (n = 0; n < `NUM_OFFSETS; n++) begin
            wb(1'b0, 8'(`ADR_OFFSET_BASE + 4 * n), 0);
            chk("offset", `OFFSET_RESET, rdat);
        end
        wb(1'b0, 8'h40, 0);
        chk("unmapped", 0, rdat);
        a_to_b();
        b_to_a();
        bypass();
        mid_reset();
        test_done();
    end
endmodule
